// File: rtc_partner.sv
// Purpose: model of the bus transceivers and the host memory arbiter
// Assumes: host grants after two or five edges, as the bench selects
// Notes: abort withdraws the grant at once to exercise the enable path
`timescale 1ns/10ps
`default_nettype none
module rtc_partner (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic abort_in,
	input wire logic nom_bit_in,
	input wire logic red_bit_in,
	input wire logic [15:0] word_in,
	input wire logic [5:0] check_in,
	input wire logic bus_request_n_in,
	output logic bus_grant_n_out,
	output logic nom_rx_pos_out,
	output logic nom_rx_neg_out,
	output logic red_rx_pos_out,
	output logic red_rx_neg_out,
	output logic [15:0] host_addr_out,
	output logic [15:0] host_data_out,
	output logic [5:0] host_check_out
);
	logic grant_r;
	logic [2:0] wait_r;

	// ----------------------------------------------------------------
	// Arbiter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			grant_r <= 1'h0;
			wait_r <= 3'h0;
		end else if (bus_request_n_in || abort_in) begin
			grant_r <= 1'h0;
			wait_r <= 3'h0;
		end else if (wait_r == (slow_in ? 3'h4 : 3'h1)) begin
			grant_r <= 1'h1;
		end else begin
			wait_r <= wait_r + 3'h1;
		end
	end
	assign bus_grant_n_out = !grant_r || abort_in;

	// ----------------------------------------------------------------
	// Lines
	// ----------------------------------------------------------------
	// Lines move on the rising edge, clear of the falling-edge sampler
	// Redundant pair follows its own bit, driven complementary like the nominal pair
	always_ff @(posedge clk_in) begin
		nom_rx_pos_out <= nom_bit_in;
		nom_rx_neg_out <= !nom_bit_in;
		red_rx_pos_out <= red_bit_in;
		red_rx_neg_out <= !red_bit_in;
	end
	// A released bus shows the inverse, never the old word
	assign host_data_out = grant_r ? word_in : ~word_in;
	assign host_addr_out = grant_r ? {word_in[7:0], word_in[15:8]} : ~word_in;
	assign host_check_out = grant_r ? check_in : ~check_in;
endmodule
`default_nettype wire

// File: rtc_pkg.sv
// Purpose: shared constants of the bus configuration and pin interface block
// Assumes: core clock of 40 MHz
// Notes: cycle counts derive from printed times and the clock period
package rtc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int TMO_LONG_US = 31;
	localparam int TMO_SHORT_US = 14;
	localparam int TMO_W = 11;
	// Timeouts are least times, so they round up to whole cycles
	localparam logic [TMO_W-1:0] TMO_LONG_CYC =
		TMO_W'((TMO_LONG_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TMO_W-1:0] TMO_SHORT_CYC =
		TMO_W'((TMO_SHORT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 3;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CHECK_W = 6;
	localparam int CFG_W = 16;
	localparam int RX_LINES = 4;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
	localparam logic TX_INHIBIT_RST = 1'h1;
	localparam logic REQ_N_RST = 1'h1;
	localparam logic OE_RST = 1'h0;
	// Request holdoff after a release: two cycles of late grant release plus
	// the resynchroniser delay, so a stale grant is never trusted
	localparam logic [2:0] REQ_GAP_CYC = 3'h5;

endpackage

// File: rtc_sync.sv
// Purpose: three-stage resynchroniser with agreement filter
// Assumes: inputs come from outside the core clock domain
// Notes: output follows only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module rtc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	import rtc_pkg::*;

	logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r;
	logic [WIDTH-1:0] q_nxt;

	// ----------------------------------------------------------------
	// Filter
	// ----------------------------------------------------------------
	// Stage one feeds stage two only, to keep metastability contained
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign q_out = q_r;

	a_sync_agree: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(s2_r == s3_r) |=> (q_r == $past(s3_r)))
		else $error("sync output missed an agreed value");

endmodule
`default_nettype wire

// File: rtc_top.sv
// Purpose: strap handling, bus line interface and host memory pins of a terminal core
// Assumes: protocol, memory sequencing and error handling sit outside this block
// Notes: pin and strap inputs are resynchronised before use, except the bus level strap, and the grant where it gates the address enable
//
// Behaviour
// - Terminal-to-terminal timeout is 31 us with select low, 14 us high.
// - Loop test is disabled while the resynchronised loop inhibit input is 1.
// - Encoder outputs on both buses are disabled while encoder inhibit is 1.
// - Configuration loads from bus commands only while the load enable is set.
// - Nominal bus receive lines are sampled on both clock edges.
// - Transmit lines rest at the bus level strap value, taken from the strap without a register.
// - Nominal transmit inhibit is registered and resets to 1.
// - Redundant transmit inhibit resets to 1; redundant lines behave like nominal.
// - Address enable resets low and drops at once when grant is withdrawn.
// - Six check bits are resynchronised; address and data outputs reset to zero.
`timescale 1ns/10ps
`default_nettype none
module rtc_top (
	input wire logic clk_in,
	input wire logic rstn_in,
	// Straps and configuration inputs
	input wire logic timeout_sel_in,
	input wire logic dyn_cfg_load_en_in,
	input wire logic bcast_accept_en_in,
	input wire logic loop_test_inhibit_n_in,
	input wire logic encoder_inhibit_n_in,
	input wire logic bus_level_in,
	// Bus lines
	input wire logic nom_rx_pos_in,
	input wire logic nom_rx_neg_in,
	input wire logic red_rx_pos_in,
	input wire logic red_rx_neg_in,
	output logic nom_tx_pos_out,
	output logic nom_tx_neg_out,
	output logic nom_tx_inhibit_out,
	output logic red_tx_pos_out,
	output logic red_tx_neg_out,
	output logic red_tx_inhibit_out,
	// Core side: receive samples, {rising, falling} per line
	output logic [1:0] nom_rx_pos_samp_out,
	output logic [1:0] nom_rx_neg_samp_out,
	output logic [1:0] red_rx_pos_samp_out,
	output logic [1:0] red_rx_neg_samp_out,
	// Core side: transmit requests
	input wire logic nom_tx_en_in,
	input wire logic nom_tx_data_in,
	input wire logic red_tx_en_in,
	input wire logic red_tx_data_in,
	// Core side: timeout, loop test, configuration, commands
	input wire logic rt_wait_start_in,
	input wire logic rt_wait_stop_in,
	output logic rt_timeout_out,
	input wire logic loop_test_req_in,
	output logic loop_test_en_out,
	input wire logic cfg_load_strobe_in,
	input wire logic [rtc_pkg::CFG_W-1:0] cfg_word_in,
	output logic [rtc_pkg::CFG_W-1:0] cfg_reg_out,
	input wire logic cmd_valid_in,
	input wire logic cmd_is_bcast_in,
	output logic cmd_accept_out,
	// Core side: memory access
	input wire logic mem_req_in,
	input wire logic mem_drive_in,
	input wire logic [rtc_pkg::ADDR_W-1:0] mem_addr_in,
	input wire logic [rtc_pkg::DATA_W-1:0] mem_wdata_in,
	output logic mem_granted_out,
	output logic [rtc_pkg::ADDR_W-1:0] mem_addr_rd_out,
	output logic [rtc_pkg::DATA_W-1:0] mem_rdata_out,
	output logic [rtc_pkg::CHECK_W-1:0] mem_rcheck_out,
	// Host memory bus pins
	input wire logic [rtc_pkg::ADDR_W-1:0] host_addr_in,
	output logic [rtc_pkg::ADDR_W-1:0] host_addr_out,
	output logic host_addr_oe_out,
	input wire logic [rtc_pkg::DATA_W-1:0] host_data_in,
	output logic [rtc_pkg::DATA_W-1:0] host_data_out,
	input wire logic [rtc_pkg::CHECK_W-1:0] host_check_in,
	input wire logic bus_grant_n_in,
	output logic bus_request_n_out
);
	import rtc_pkg::*;

	// ----------------------------------------------------------------
	// Resynchronised straps and control inputs
	// ----------------------------------------------------------------
	logic to_sel_s, dyn_s, bcast_s, loop_inh_s, enc_inh_s, grant_s;
	// Grant goes through active high so the pipe's reset value reads as not granted
	rtc_sync #(.WIDTH(6)) u_cfg_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in({timeout_sel_in, dyn_cfg_load_en_in, bcast_accept_en_in,
			loop_test_inhibit_n_in, encoder_inhibit_n_in, !bus_grant_n_in}),
		.q_out({to_sel_s, dyn_s, bcast_s, loop_inh_s, enc_inh_s, grant_s})
	);

	// ----------------------------------------------------------------
	// Receive sampling on both edges
	// ----------------------------------------------------------------
	logic [RX_LINES-1:0] rx_pins, rx_fall_r, rx_rise_s, rx_fall_s;

	assign rx_pins = {red_rx_neg_in, red_rx_pos_in, nom_rx_neg_in, nom_rx_pos_in};

	// Falling-edge capture halves the effective sampling period
	always_ff @(negedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_fall_r <= '0;
		end else begin
			rx_fall_r <= rx_pins;
		end
	end
	rtc_sync #(.WIDTH(RX_LINES)) u_rx_rise_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in(rx_pins),
		.q_out(rx_rise_s)
	);
	rtc_sync #(.WIDTH(RX_LINES)) u_rx_fall_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in(rx_fall_r),
		.q_out(rx_fall_s)
	);

	assign nom_rx_pos_samp_out = {rx_rise_s[0], rx_fall_s[0]};
	assign nom_rx_neg_samp_out = {rx_rise_s[1], rx_fall_s[1]};
	// Redundant lines take the same path as the nominal ones
	assign red_rx_pos_samp_out = {rx_rise_s[2], rx_fall_s[2]};
	assign red_rx_neg_samp_out = {rx_rise_s[3], rx_fall_s[3]};

	// ----------------------------------------------------------------
	// Transmit lines
	// ----------------------------------------------------------------
	// Registers hold the deviation from the idle level; the strap is
	// hard-wired, so folding it in keeps the idle level right even in reset.
	logic nom_pos_r, nom_neg_r, nom_inh_r, red_pos_r, red_neg_r, red_inh_r;
	logic nom_pos_nxt, nom_neg_nxt, nom_inh_nxt, red_pos_nxt, red_neg_nxt, red_inh_nxt;

	always_comb begin
		nom_inh_nxt = enc_inh_s || !nom_tx_en_in;
		red_inh_nxt = enc_inh_s || !red_tx_en_in;
		nom_pos_nxt = !nom_inh_nxt && (nom_tx_data_in ^ bus_level_in);
		nom_neg_nxt = !nom_inh_nxt && (!nom_tx_data_in ^ bus_level_in);
		red_pos_nxt = !red_inh_nxt && (red_tx_data_in ^ bus_level_in);
		red_neg_nxt = !red_inh_nxt && (!red_tx_data_in ^ bus_level_in);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nom_inh_r <= TX_INHIBIT_RST;
			red_inh_r <= TX_INHIBIT_RST;
			nom_pos_r <= 1'h0;
			nom_neg_r <= 1'h0;
			red_pos_r <= 1'h0;
			red_neg_r <= 1'h0;
		end else begin
			nom_inh_r <= nom_inh_nxt;
			red_inh_r <= red_inh_nxt;
			nom_pos_r <= nom_pos_nxt;
			nom_neg_r <= nom_neg_nxt;
			red_pos_r <= red_pos_nxt;
			red_neg_r <= red_neg_nxt;
		end
	end

	assign nom_tx_pos_out = nom_pos_r ^ bus_level_in;
	assign nom_tx_neg_out = nom_neg_r ^ bus_level_in;
	assign red_tx_pos_out = red_pos_r ^ bus_level_in;
	assign red_tx_neg_out = red_neg_r ^ bus_level_in;
	assign nom_tx_inhibit_out = nom_inh_r;
	assign red_tx_inhibit_out = red_inh_r;

	a_tx_inhibit_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
		enc_inh_s |=> (nom_tx_inhibit_out && red_tx_inhibit_out))
		else $error("encoder inhibit did not silence both buses");

	a_tx_idle_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
		nom_tx_inhibit_out |-> (nom_tx_pos_out == bus_level_in
			&& nom_tx_neg_out == bus_level_in))
		else $error("nominal idle lines differ from bus level");

	a_red_tx_pair: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!red_tx_inhibit_out |-> (red_tx_pos_out != red_tx_neg_out))
		else $error("redundant lines not complementary while sending");

	// ----------------------------------------------------------------
	// Terminal-to-terminal response timeout
	// ----------------------------------------------------------------
	logic wait_r, wait_nxt, tmo_r, tmo_nxt;
	logic [TMO_W-1:0] cnt_r, cnt_nxt, tmo_lim;

	assign tmo_lim = to_sel_s ? TMO_SHORT_CYC : TMO_LONG_CYC;
	always_comb begin
		wait_nxt = wait_r;
		cnt_nxt = cnt_r;
		tmo_nxt = 1'h0;
		if (rt_wait_start_in) begin
			wait_nxt = 1'h1;
			cnt_nxt = '0;
		end else if (rt_wait_stop_in) begin
			wait_nxt = 1'h0;
		end else if (wait_r) begin
			if (cnt_r == tmo_lim - TMO_W'(1)) begin
				wait_nxt = 1'h0;
				tmo_nxt = 1'h1;
			end else begin
				cnt_nxt = cnt_r + TMO_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_r <= 1'h0;
			cnt_r <= '0;
			tmo_r <= 1'h0;
		end else begin
			wait_r <= wait_nxt;
			cnt_r <= cnt_nxt;
			tmo_r <= tmo_nxt;
		end
	end

	assign rt_timeout_out = tmo_r;
	a_timeout_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
		tmo_r |-> ($past(cnt_r) == (to_sel_s ? 11'h22f : 11'h4d7)
			|| $changed(to_sel_s)))
		else $error("timeout fired at the wrong count");

	// ----------------------------------------------------------------
	// Loop test, dynamic configuration and broadcast acceptance
	// ----------------------------------------------------------------
	logic loop_r, loop_nxt, acc_r, acc_nxt;
	logic [CFG_W-1:0] cfg_r, cfg_nxt;

	always_comb begin
		loop_nxt = loop_test_req_in && !loop_inh_s;
		cfg_nxt = (cfg_load_strobe_in && dyn_s) ? cfg_word_in : cfg_r;
		acc_nxt = cmd_valid_in && (!cmd_is_bcast_in || bcast_s);
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			loop_r <= 1'h0;
			cfg_r <= CFG_RST;
			acc_r <= 1'h0;
		end else begin
			loop_r <= loop_nxt;
			cfg_r <= cfg_nxt;
			acc_r <= acc_nxt;
		end
	end

	assign loop_test_en_out = loop_r;
	assign cfg_reg_out = cfg_r;
	assign cmd_accept_out = acc_r;

	a_loop_blocked: assert property (@(posedge clk_in) disable iff (!rstn_in)
		loop_inh_s |=> !loop_test_en_out)
		else $error("loop test enabled while inhibited");

	a_cfg_blocked: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!(cfg_load_strobe_in && dyn_s) |=> $stable(cfg_reg_out))
		else $error("configuration changed without enabled load");

	a_cfg_loaded: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(cfg_load_strobe_in && dyn_s) |=> (cfg_reg_out == $past(cfg_word_in)))
		else $error("enabled configuration load was lost");

	a_bcast_drop: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(cmd_valid_in && cmd_is_bcast_in && !bcast_s) |=> !cmd_accept_out)
		else $error("broadcast accepted while disabled");

	// ----------------------------------------------------------------
	// Host memory bus
	// ----------------------------------------------------------------
	// A new request waits out the holdoff after a release; a host that holds
	// the grant beyond two cycles after release makes the next request look granted.
	logic req_n_r, req_n_nxt, oe_r, oe_nxt;
	logic [2:0] gap_r, gap_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] data_r, data_nxt;
	logic granted;

	assign granted = !req_n_r && grant_s;

	always_comb begin
		gap_nxt = (!req_n_r || gap_r == REQ_GAP_CYC) ? (req_n_r ? gap_r : 3'h0) : gap_r + 3'h1;
		req_n_nxt = !(mem_req_in && (!req_n_r || gap_r == REQ_GAP_CYC));
		oe_nxt = mem_req_in && granted;
		addr_nxt = addr_r;
		data_nxt = data_r;
		if (mem_req_in && granted && mem_drive_in) begin
			addr_nxt = mem_addr_in;
			data_nxt = mem_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			req_n_r <= REQ_N_RST;
			gap_r <= REQ_GAP_CYC;
			oe_r <= OE_RST;
			addr_r <= ADDR_RST;
			data_r <= DATA_RST;
		end else begin
			req_n_r <= req_n_nxt;
			gap_r <= gap_nxt;
			oe_r <= oe_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
		end
	end

	// Combinational path lets the enable fall the moment grant goes away
	assign host_addr_oe_out = oe_r && !bus_grant_n_in;
	assign bus_request_n_out = req_n_r;
	assign mem_granted_out = granted;
	assign host_addr_out = addr_r;
	assign host_data_out = data_r;

	rtc_sync #(.WIDTH(ADDR_W + DATA_W + CHECK_W)) u_host_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.d_in({host_addr_in, host_data_in, host_check_in}),
		.q_out({mem_addr_rd_out, mem_rdata_out, mem_rcheck_out})
	);

	a_oe_grant: assert property (@(posedge clk_in) disable iff (!rstn_in)
		bus_grant_n_in |-> !host_addr_oe_out)
		else $error("address enable high without grant");

	a_oe_needs_req: assert property (@(posedge clk_in) disable iff (!rstn_in)
		host_addr_oe_out |-> ($past(!req_n_r) && $past(mem_req_in)))
		else $error("address enable without a granted request");

endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench of the configuration and pin interface block
// Assumes: inputs change on the falling edge of the clock
// Notes: strap-dependent checks wait six cycles for the resynchronisers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rtc_pkg::*;
	logic clk_in, rstn_in, sel, dyn, bc, loop_inh, enc_inh, lvl;
	logic nom_en, nom_d, red_en, red_d, w_start, w_stop, loop_req, cfg_stb, cmd_v, cmd_bc;
	logic mem_req, mem_drv, slow, abort, nom_b, red_b;
	logic [15:0] cfg_w, mem_a, mem_w, word, kept;
	logic [5:0] chk;
	logic nrp, nrn, rrp, rrn, grant_n;
	logic [15:0] h_a, h_d;
	logic [5:0] h_c;
	logic ntp, ntn, nti, rtp, rtn, rti, tmo, lte, acc, gnt, oe, req_n;
	logic [1:0] s_np, s_nn, s_rp, s_rn;
	logic [15:0] cfg_q, a_rd, rd, a_o, d_o;
	logic [5:0] rc;
	logic [31:0] seed;
	int err_total, comparisons, n;

	rtc_top rtc_top_i (.clk_in(clk_in), .rstn_in(rstn_in), .timeout_sel_in(sel),
		.dyn_cfg_load_en_in(dyn), .bcast_accept_en_in(bc), .loop_test_inhibit_n_in(loop_inh),
		.encoder_inhibit_n_in(enc_inh), .bus_level_in(lvl), .nom_rx_pos_in(nrp),
		.nom_rx_neg_in(nrn), .red_rx_pos_in(rrp), .red_rx_neg_in(rrn), .nom_tx_pos_out(ntp),
		.nom_tx_neg_out(ntn), .nom_tx_inhibit_out(nti), .red_tx_pos_out(rtp),
		.red_tx_neg_out(rtn), .red_tx_inhibit_out(rti), .nom_rx_pos_samp_out(s_np),
		.nom_rx_neg_samp_out(s_nn), .red_rx_pos_samp_out(s_rp), .red_rx_neg_samp_out(s_rn),
		.nom_tx_en_in(nom_en), .nom_tx_data_in(nom_d), .red_tx_en_in(red_en),
		.red_tx_data_in(red_d), .rt_wait_start_in(w_start), .rt_wait_stop_in(w_stop),
		.rt_timeout_out(tmo), .loop_test_req_in(loop_req), .loop_test_en_out(lte),
		.cfg_load_strobe_in(cfg_stb), .cfg_word_in(cfg_w), .cfg_reg_out(cfg_q),
		.cmd_valid_in(cmd_v), .cmd_is_bcast_in(cmd_bc), .cmd_accept_out(acc),
		.mem_req_in(mem_req), .mem_drive_in(mem_drv), .mem_addr_in(mem_a),
		.mem_wdata_in(mem_w), .mem_granted_out(gnt), .mem_addr_rd_out(a_rd),
		.mem_rdata_out(rd), .mem_rcheck_out(rc), .host_addr_in(h_a), .host_addr_out(a_o),
		.host_addr_oe_out(oe), .host_data_in(h_d), .host_data_out(d_o), .host_check_in(h_c),
		.bus_grant_n_in(grant_n), .bus_request_n_out(req_n));
	rtc_partner rtc_partner_i (.clk_in(clk_in), .rstn_in(rstn_in), .slow_in(slow),
		.abort_in(abort), .nom_bit_in(nom_b), .red_bit_in(red_b), .word_in(word),
		.check_in(chk), .bus_request_n_in(req_n), .bus_grant_n_out(grant_n),
		.nom_rx_pos_out(nrp), .nom_rx_neg_out(nrn), .red_rx_pos_out(rrp),
		.red_rx_neg_out(rrn), .host_addr_out(h_a), .host_data_out(h_d), .host_check_out(h_c));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic void rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
	endfunction
	task automatic step(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	function automatic logic [1:0] tx_exp(input logic en, input logic d, input logic l);
		return en ? {d, !d} : {l, l};
	endfunction
	function automatic logic [15:0] tmo_exp(input int p);
		return (p == 2) ? 16'h0578 : 16'(p ? TMO_SHORT_CYC : TMO_LONG_CYC);
	endfunction
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		clk_in = 1'h0;
		forever #12.5 clk_in = !clk_in;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{rstn_in, sel, dyn, bc, loop_inh, enc_inh, lvl, nom_en, nom_d, red_en, red_d} = '0;
		{w_start, w_stop, loop_req, cfg_stb, cmd_v, cmd_bc, mem_req, mem_drv} = '0;
		{slow, abort, nom_b, red_b, cfg_w, mem_a, mem_w, word, chk, kept} = '0;
		err_total = 0;
		comparisons = 0;
		seed = 32'h00012c11;
		for (int l = 0; l < 2; l++) begin
			lvl = l[0];
			rstn_in = 1'h0;
			step(20);
			check("nom tx idle", {ntp, ntn}, {l[0], l[0]});
			check("red tx idle", {rtp, rtn}, {l[0], l[0]});
			rstn_in = 1'h1;
			step(6);
			check("inhibits", {nti, rti}, 2'h3);
			check("addr out", a_o, 16'h0000);
			check("data out", d_o, 16'h0000);
			check("oe and req", {oe, req_n}, 2'h1);
		end
		$display("test reset done");
		for (int p = 0; p < 2; p++) begin
			enc_inh = p[0];
			step(6);
			for (int i = 0; i < 16; i++) begin
				rnd();
				{nom_en, nom_d, red_en, red_d} = seed[3:0];
				step(1);
				check("nom tx", {ntp, ntn}, tx_exp(nom_en & !p[0], nom_d, lvl));
				check("nom inh", nti, !(nom_en & !p[0]));
				check("red tx", {rtp, rtn}, tx_exp(red_en & !p[0], red_d, lvl));
				check("red inh", rti, !(red_en & !p[0]));
			end
		end
		{nom_en, red_en} = 2'h0;
		$display("test transmit done");
		loop_req = 1'h1;
		for (int p = 0; p < 2; p++) begin
			loop_inh = p[0];
			step(6);
			check("loop en", lte, !p[0]);
		end
		for (int p = 1; p >= 0; p--) begin
			dyn = p[0];
			step(6);
			rnd();
			cfg_w = seed[15:0];
			cfg_stb = 1'h1;
			step(1);
			cfg_stb = 1'h0;
			if (p == 1)
				kept = seed[15:0];
			check("cfg reg", cfg_q, kept);
		end
		for (int k = 0; k < 4; k++) begin
			bc = k[1];
			step(6);
			cmd_bc = k[0];
			cmd_v = 1'h1;
			step(1);
			cmd_v = 1'h0;
			check("cmd accept", acc, !k[0] || k[1]);
		end
		$display("test strap inputs done");
		for (int i = 0; i < 8; i++) begin
			rnd();
			{nom_b, red_b} = seed[1:0];
			step(7);
			check("nom rx samp", {s_np, s_nn}, {{2{nom_b}}, {2{!nom_b}}});
			check("red rx samp", {s_rp, s_rn}, {{2{red_b}}, {2{!red_b}}});
		end
		$display("test receive done");
		for (int s = 0; s < 2; s++) begin
			rnd();
			{slow, mem_drv, mem_req} = {s[0], 2'h3};
			{mem_a, mem_w, word, chk} = {seed[15:0], ~seed[15:0], seed[31:16], seed[21:16]};
			n = 0;
			while (gnt !== 1'h1 && n < 20) begin
				step(1);
				n++;
			end
			check("granted", gnt, 1'h1);
			step(1);
			check("oe on", oe, 1'h1);
			check("addr drive", a_o, mem_a);
			check("data drive", d_o, mem_w);
			step(5);
			check("rdata", rd, word);
			check("rcheck", rc, chk);
			check("addr rd", a_rd, {word[7:0], word[15:8]});
			if (s == 1) begin
				abort = 1'h1;
				#1;
				check("oe drop", oe, 1'h0);
				step(1);
				abort = 1'h0;
			end
			mem_req = 1'h0;
			step(3);
			check("released", {oe, req_n}, 2'h1);
		end
		$display("test memory done");
		for (int p = 0; p < 3; p++) begin
			sel = (p == 1);
			step(6);
			w_start = 1'h1;
			step(1);
			w_start = 1'h0;
			n = 0;
			while (tmo !== 1'h1 && n < 1400) begin
				w_stop = (p == 2 && n == 100);
				step(1);
				n++;
			end
			w_stop = 1'h0;
			check("timeout cycles", n[15:0], tmo_exp(p));
			step(1);
			check("timeout pulse", tmo, 1'h0);
		end
		$display("test timeout done");
		report_and_stop();
	end
endmodule
`default_nettype wire
